// ===== logic/sar_ctl.sv
// control logic of a dual simultaneous-sampling 12-bit sar converter
// assumes all pins sampled synchronously on the converter clock mclk_i;
// comparator outputs come from the analog core, one per converter.
//
// Function
// - two pick bits choose the input pair for both converters alike.
// - after conversion, precharge both capacitors exactly one clock, then reconnect.
// - busy low during acquisition, from switch close to conversion start fall.
// - both converters hold their inputs at conversion start falling edge.
// - conversion begins on the clock edge after the start falling edge.
// - twelve conversion clocks, one precharge, at least two sampling clocks.
// - clock may stop low after sixteenth edge; state is kept.
// - dac write completes within fourteen clocks; clock may then stop.
// - power-on reset returns all control state to defaults.
// - reference set by 10-bit dac code held in dac register.
// - dac register resets to full scale 3ff.
// - setup bit 4 set turns internal reference off.
// - setup word latched from data bus at write strobe rising edge.
// - setup register resets to zero.
// - setup layout: pick, gate, deep, nap, auto, vref off, x, function.
// - gate 01 enables extra register updates; 00, 11 disable; 10 reserved.
// - each sleep bit set enters its power-down mode.
// - function codes select dac or sequencer access, or software reset.
// - each result reads once; repeat read returns 000.
// - results presented in twos complement.
`timescale 1ns/100ps
`include "sar_ctl_defs.svh"


module sar_ctl
   import sar_ctl_pkg::*;
(
   input  wire logic                 mclk_i,          // converter clock
   input  wire logic                 rstn_i,          // power-on reset, active low
   input  wire logic                 conv_begin_n_i,  // conversion start, falls to sample
   input  wire logic                 cs_n_i,          // chip select
   input  wire logic                 wr_n_i,          // write strobe
   input  wire logic                 rd_n_i,          // read strobe
   input  wire logic [11:0]          data_bus_i,      // parallel data in
   input  wire logic [1:0]           comp_i,          // comparators, bit0 conv a
   output logic [11:0]               data_bus_o,      // parallel data out
   output logic                      data_bus_oe_n_o, // low while driving bus
   output logic                      busy_o,          // conversion in progress
   output logic                      hold_o,          // sample switches open
   output logic                      precharge_o,     // caps tied to vref_input
   output sar_ctl_pkg::setup_t       setup_o,         // live setup word
   output logic [9:0]                vref_output_o,   // reference dac code
   output logic                      sleep_o,         // core in any sleep mode: deep, nap or auto idle
   output logic [1:0][11:0]          trial_o          // sar trial codes a, b
);
   import sar_ctl_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // decode helpers

   function automatic logic gate_open(input setup_t s);
      gate_open = (s.update_gate == `GATE_OPEN);
   endfunction

   function automatic setup_t clean_setup(input logic [11:0] w);
      setup_t s;
      s = setup_t'(w);
      s.dont_care = 1'b0;
      clean_setup = s;
   endfunction

   // comparator code to twos complement: flip the msb
   function automatic logic [11:0] to_twos(input logic [11:0] code);
      to_twos = {!code[11], code[10:0]};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // strobe edges

   logic conv_q;
   logic wr_q;
   logic rd_q;
   logic cs_wr_q;

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         conv_q  <= 1'b1;
         wr_q    <= 1'b1;
         rd_q    <= 1'b1;
         cs_wr_q <= 1'b0;
      end else begin
         conv_q  <= conv_begin_n_i;
         wr_q    <= wr_n_i;
         rd_q    <= rd_n_i;
         cs_wr_q <= !cs_n_i && !wr_n_i;
      end
   end

   wire logic conv_fall = conv_q && !conv_begin_n_i;
   wire logic wr_rise   = cs_wr_q && !wr_q && wr_n_i;
   wire logic rd_fall   = !cs_n_i && rd_q && !rd_n_i;

   ////////////////////////////////////////////////////////////////////////////
   // setup word, dac register, two-access protocol

   setup_t     setup;
   logic [9:0] dac_code;
   next_acc_t  next_acc;

   wire setup_t     wr_word    = clean_setup(data_bus_i);
   wire logic       acc_idle   = next_acc == NX_NONE;
   wire logic       soft_rst   = wr_rise && acc_idle
                                 && wr_word.func_code == `FN_SOFT_RST;
   wire logic       take_setup = wr_rise && acc_idle && !soft_rst;
   wire logic       take_dac   = wr_rise && next_acc == NX_DAC_WR;
   wire logic       rd_dac     = rd_fall && next_acc == NX_DAC_RD;

   next_acc_t next_next_acc;
   always_comb begin
      next_next_acc = next_acc;
      if (wr_rise && next_acc != NX_NONE) begin
         next_next_acc = NX_NONE;
      end else if (rd_dac) begin
         next_next_acc = NX_NONE;
      end else if (take_setup && gate_open(wr_word)) begin
         case (wr_word.func_code)
            `FN_DAC_WR: next_next_acc = NX_DAC_WR;
            `FN_DAC_RD: next_next_acc = NX_DAC_RD;
            `FN_SEQ_WR: next_next_acc = NX_SEQ_WR;
            default:    next_next_acc = NX_NONE;
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         setup    <= setup_t'(`SETUP_RST);
         dac_code <= `DAC_RST;
         next_acc <= NX_NONE;
      end else if (soft_rst) begin
         setup    <= setup_t'(`SETUP_RST);
         dac_code <= `DAC_RST;
         next_acc <= NX_NONE;
      end else begin
         if (take_setup) begin
            setup <= wr_word;
         end
         if (take_dac) begin
            dac_code <= data_bus_i[9:0];
         end
         next_acc <= next_next_acc;
      end
   end

   // picks, sleep bits and reference off reach the analog core directly
   assign setup_o       = setup;
   assign vref_output_o = dac_code;

   ////////////////////////////////////////////////////////////////////////////
   // conversion sequence
   // nothing measures time, so a clock stopped low freezes the cycle

   phase_t     phase;
   phase_t     next_phase;
   logic [3:0] bit_cnt;
   logic [1:0] acq_cnt;
   logic       napping;

   wire logic  conv_ok   = !setup.deep_sleep && !setup.nap_sleep;
   // a start before the caps have sampled two clocks is dropped,
   // so every cycle spans at least sixteen clocks
   wire logic  acq_ok    = acq_cnt == `ACQ_MIN_CYCLES;
   wire logic  conv_go   = phase == ST_ACQ && conv_fall && conv_ok && acq_ok;
   wire logic  conv_last = phase == ST_CONV && bit_cnt == `CONV_CYCLES - 4'h1;

   always_comb begin
      case (phase)
         ST_ACQ:   next_phase = conv_go ? ST_CONV : ST_ACQ;
         ST_CONV:  next_phase = conv_last ? ST_PRECH : ST_CONV;
         ST_PRECH: next_phase = ST_ACQ;
         default:  next_phase = ST_ACQ;
      endcase
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         phase   <= ST_ACQ;
         bit_cnt <= 4'h0;
         acq_cnt <= `ACQ_MIN_CYCLES;
         napping <= 1'b0;
      end else begin
         phase   <= next_phase;
         bit_cnt <= (phase == ST_CONV) ? bit_cnt + 4'h1 : 4'h0;
         // sampling clocks since precharge, held at the minimum
         if (phase != ST_ACQ) begin
            acq_cnt <= 2'h0;
         end else if (acq_cnt != `ACQ_MIN_CYCLES) begin
            acq_cnt <= acq_cnt + 2'h1;
         end
         if (conv_go || !setup.auto_idle_sleep) begin
            napping <= 1'b0;
         end else if (phase == ST_PRECH) begin
            napping <= 1'b1;
         end
      end
   end

   wire logic  sleep_any = setup.deep_sleep || setup.nap_sleep || napping;

   // pin outputs registered: busy, hold and precharge from the next phase, sleep from sleep_any
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         busy_o      <= 1'b0;
         hold_o      <= 1'b0;
         precharge_o <= 1'b0;
         sleep_o     <= 1'b0;
      end else begin
         busy_o      <= next_phase != ST_ACQ;
         hold_o      <= next_phase == ST_CONV;
         precharge_o <= next_phase == ST_PRECH;
         sleep_o     <= sleep_any;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // successive approximation, one per converter

   logic [11:0]      trial_bit;
   logic [1:0][11:0] sar;
   logic [1:0][11:0] next_sar;

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         trial_bit <= 12'h000;
      end else if (conv_go) begin
         trial_bit <= `SAR_FIRST_TRIAL;
      end else if (phase == ST_CONV) begin
         trial_bit <= trial_bit >> 1;
      end
   end

   generate
      for (genvar i = 0; i < 2; i++) begin : g_sar
         assign next_sar[i] = (sar[i] & ~(trial_bit & {12{!comp_i[i]}}))
                              | (trial_bit >> 1);
         always_ff @(posedge mclk_i or negedge rstn_i) begin
            if (!rstn_i) begin
               sar[i] <= 12'h000;
            end else if (conv_go) begin
               sar[i] <= `SAR_FIRST_TRIAL;
            end else if (phase == ST_CONV) begin
               sar[i] <= next_sar[i];
            end
         end
      end
   endgenerate

   assign trial_o = sar;

   ////////////////////////////////////////////////////////////////////////////
   // result registers and read path

   logic [1:0][11:0] result;
   logic [1:0]       res_vld;
   logic             rd_sel;

   wire logic        rd_result = rd_fall && !rd_dac;
   wire logic [11:0] rd_word   = res_vld[rd_sel] ? result[rd_sel] : `RES_EMPTY;

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         result  <= '0;
         res_vld <= 2'h0;
         rd_sel  <= 1'b0;
      end else begin
         if (rd_result) begin
            res_vld[rd_sel] <= 1'b0;
            rd_sel          <= !rd_sel;
         end
         // a finishing conversion wins over a read in the same clock
         if (conv_last) begin
            result[0] <= to_twos(next_sar[0]);
            result[1] <= to_twos(next_sar[1]);
            res_vld   <= 2'h3;
            rd_sel    <= 1'b0;
         end
      end
   end

   // bus keeps the last read word; enable follows strobes one clock late
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         data_bus_o      <= 12'h000;
         data_bus_oe_n_o <= 1'b1;
      end else begin
         data_bus_oe_n_o <= cs_n_i || rd_n_i;
         if (rd_dac) begin
            data_bus_o <= {2'h0, dac_code};
         end else if (rd_result) begin
            data_bus_o <= rd_word;
         end
      end
   end

endmodule

// ===== logic/sar_ctl_defs.svh
// constants for the dual sar converter control block
// assumes inclusion from the package and the control module only
`ifndef SAR_CTL_DEFS_SVH
`define SAR_CTL_DEFS_SVH

// converter setup word
`define SETUP_W          12
`define SETUP_RST        12'h000
`define SETUP_DC_BIT     3
// register update gate encodings
`define GATE_OPEN        2'h1
// function codes
`define FN_DAC_WR        3'h1
`define FN_DAC_RD        3'h3
`define FN_SEQ_WR        3'h4
`define FN_SOFT_RST      3'h5
`define FN_SEQ_RD        3'h6
// reference dac
`define DAC_W            10
`define DAC_RST          10'h3ff
// conversion timing in clocks
`define CONV_CYCLES      4'hc
`define PRECH_CYCLES     1
`define ACQ_MIN_CYCLES   2'h2
// result word
`define RES_W            12
`define RES_EMPTY        12'h000
`define SAR_FIRST_TRIAL  12'h800

`endif

// ===== logic/sar_ctl_pkg.sv
// types for the dual sar converter control block
// assumes sar_ctl_defs.svh is on the include path
`include "sar_ctl_defs.svh"

package sar_ctl_pkg;

   // converter setup word, msb first
   typedef struct packed {
      logic [1:0] input_pick;      // input_pick_hi, input_pick_lo
      logic [1:0] update_gate;     // update_gate_hi, update_gate_lo
      logic       deep_sleep;
      logic       nap_sleep;
      logic       auto_idle_sleep;
      logic       vref_off;
      logic       dont_care;
      logic [2:0] func_code;       // func_code_2 .. func_code_0
   } setup_t;

   // conversion cycle, gray coded along acquire, convert, precharge
   typedef enum logic [1:0] {
      ST_ACQ   = 2'h0,
      ST_CONV  = 2'h1,
      ST_PRECH = 2'h3
   } phase_t;

   // what the next bus access means
   typedef enum logic [1:0] {
      NX_NONE   = 2'h0,
      NX_DAC_WR = 2'h1,
      NX_DAC_RD = 2'h2,
      NX_SEQ_WR = 2'h3
   } next_acc_t;

endpackage

// ===== tb/sar_core_model.sv
// comparator model of both converter cores
// assumes the bench changes the held inputs only while idle
`timescale 1ns/100ps
module sar_core_model (
   input  wire logic [1:0][11:0] trial_i, // trial codes a, b
   input  wire logic [11:0]      tgt_a_i, // held input a
   input  wire logic [11:0]      tgt_b_i, // held input b
   output logic [1:0]            comp_o   // keep trial bit
);
   ////////////////////////////////////////////////////////////////////////////////
   // keep the bit while the trial does not exceed the held input
   assign comp_o[0] = (trial_i[0] <= tgt_a_i);
   assign comp_o[1] = (trial_i[1] <= tgt_b_i);
endmodule

// ===== tb/sar_ctl_props.sv
// port assertions for the sar control block
// assumes a bind onto sar_ctl, single clock domain
`timescale 1ns/100ps
module sar_ctl_props
   import sar_ctl_pkg::*;
(
   input wire logic                mclk_i,          // clock
   input wire logic                rstn_i,          // reset
   input wire logic                conv_begin_n_i,  // start
   input wire logic                cs_n_i,          // select
   input wire logic                wr_n_i,          // write
   input wire logic                rd_n_i,          // read
   input wire logic [11:0]         data_bus_i,      // data in
   input wire logic [1:0]          comp_i,          // comparators
   input wire logic [11:0]         data_bus_o,      // data out
   input wire logic                data_bus_oe_n_o, // drive enable
   input wire logic                busy_o,          // busy
   input wire logic                hold_o,          // hold
   input wire logic                precharge_o,     // precharge
   input wire sar_ctl_pkg::setup_t setup_o,         // setup word
   input wire logic [9:0]          vref_output_o,   // dac code
   input wire logic                sleep_o,         // sleep
   input wire logic [1:0][11:0]    trial_o          // trials
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   ////////////////////////////////////////////////////////////////////////////////
   AST_START: assert property ($fell(conv_begin_n_i) && !busy_o && !setup_o.deep_sleep
      && !setup_o.nap_sleep && !$past(busy_o) && !$past(busy_o, 2)
      |=> busy_o && hold_o) else $error("start not taken");
   AST_ACQ_MIN: assert property ($rose(busy_o) |-> !$past(busy_o, 2) && !$past(busy_o, 3))
      else $error("sampling time too short");
   AST_CONV_LEN: assert property ($rose(hold_o) |-> ##11 hold_o
      ##1 (precharge_o && !hold_o) ##1 !busy_o) else $error("cycle length wrong");
   AST_PRECH: assert property (precharge_o |-> $past(hold_o) && !hold_o)
      else $error("precharge misplaced");
   AST_BUSY: assert property (hold_o || precharge_o |-> busy_o)
      else $error("busy low in conversion");
   AST_SETUP_WR: assert property (!$stable(setup_o) |-> $past(wr_n_i)
      && !($past(wr_n_i, 2) && $past(wr_n_i, 3))) else $error("setup moved without write");
   AST_DAC_WR: assert property (!$stable(vref_output_o) |-> $past(wr_n_i)
      && !($past(wr_n_i, 2) && $past(wr_n_i, 3))) else $error("dac moved without write");
   AST_BIT3: assert property (setup_o.dont_care == 1'b0)
      else $error("ignored bit stored");
   AST_DEEP: assert property ($fell(conv_begin_n_i) && setup_o.deep_sleep && !busy_o
      |=> !busy_o) else $error("start taken in deep sleep");
   cover property ($rose(precharge_o));
   cover property ($rose(sleep_o));
   cover property (!$stable(vref_output_o));
endmodule
bind sar_ctl sar_ctl_props u_props (.mclk_i(mclk_i), .rstn_i(rstn_i),
   .conv_begin_n_i(conv_begin_n_i), .cs_n_i(cs_n_i), .wr_n_i(wr_n_i), .rd_n_i(rd_n_i),
   .data_bus_i(data_bus_i), .comp_i(comp_i), .data_bus_o(data_bus_o),
   .data_bus_oe_n_o(data_bus_oe_n_o), .busy_o(busy_o), .hold_o(hold_o),
   .precharge_o(precharge_o), .setup_o(setup_o), .vref_output_o(vref_output_o),
   .sleep_o(sleep_o), .trial_o(trial_o));

// ===== tb/tb_dual_sar_adc_control.sv
// self-checking bench for the sar control block
// assumes sar_ctl, its bound checker and the comparator model
`timescale 1ns/100ps
module tb_dual_sar_adc_control;
   import sar_ctl_pkg::*;
   logic             mclk = 1'b0;
   logic             rstn = 1'b0;
   logic             cb_n = 1'b1;
   logic             cs_n = 1'b1;
   logic             wr_n = 1'b1;
   logic             rd_n = 1'b1;
   logic [11:0]      dbi = 12'h000;
   logic [11:0]      tgt_a = 12'h000;
   logic [11:0]      tgt_b = 12'h000;
   logic [1:0]       comp;
   logic [11:0]      dbo;
   logic             oe_n;
   logic             busy;
   logic             hold;
   logic             prech;
   logic             sleep;
   setup_t           setup;
   logic [9:0]       vref;
   logic [1:0][11:0] trial;
   logic [11:0]      q;
   int               failures = 0;
   int               n_tests = 0;
   ////////////////////////////////////////////////////////////////////////////////
   initial forever #20 mclk = ~mclk;
   sar_ctl u_dut (.mclk_i(mclk), .rstn_i(rstn), .conv_begin_n_i(cb_n), .cs_n_i(cs_n),
      .wr_n_i(wr_n), .rd_n_i(rd_n), .data_bus_i(dbi), .comp_i(comp), .data_bus_o(dbo),
      .data_bus_oe_n_o(oe_n), .busy_o(busy), .hold_o(hold), .precharge_o(prech),
      .setup_o(setup), .vref_output_o(vref), .sleep_o(sleep), .trial_o(trial));
   sar_core_model u_core (.trial_i(trial), .tgt_a_i(tgt_a), .tgt_b_i(tgt_b), .comp_o(comp));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic wr(input logic [11:0] d);
      @(posedge mclk);
      cs_n <= 1'b0;
      wr_n <= 1'b0;
      dbi <= d;
      @(posedge mclk);
      wr_n <= 1'b1;
      @(posedge mclk);
      cs_n <= 1'b1;
      tick(2);
   endtask
   task automatic rd(output logic [11:0] d);
      @(posedge mclk);
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      tick(3);
      d = dbo;
      chk("drive enable", 12'h000, {11'h000, oe_n});
      rd_n <= 1'b1;
      cs_n <= 1'b1;
      tick(2);
      chk("drive enable", 12'h001, {11'h000, oe_n});
   endtask
   // waits out busy before releasing the start line
   task automatic conv(input logic [11:0] a, input logic [11:0] b, input logic eb);
      int n_clk = 0;
      int n_pre = 0;
      tgt_a <= a;
      tgt_b <= b;
      @(posedge mclk);
      cb_n <= 1'b0;
      tick(2);
      chk("busy", {11'h000, eb}, {11'h000, busy});
      chk("hold", {11'h000, eb}, {11'h000, hold});
      while (n_clk < 30 && busy !== 1'b0) begin
         if (prech === 1'b1) n_pre++;
         n_clk++;
         tick(1);
      end
      if (busy !== 1'b0) begin
         failures++;
         end_of_test();
      end
      chk("cycle clocks", eb ? 12'h00d : 12'h000, n_clk[11:0]);
      chk("precharge clocks", {11'h000, eb}, n_pre[11:0]);
      cb_n <= 1'b1;
      tick(3);
   endtask
   task automatic t_defaults();
      chk("setup", 12'h000, setup);
      chk("vref", 12'h3ff, {2'h0, vref});
      chk("busy", 12'h000, {11'h000, busy});
   endtask
   task automatic t_setup();
      logic [11:0] w;
      for (int p = 0; p < 4; p++) begin
         w = {p[1:0], 2'h0, 3'h0, p[0], 1'b1, 3'h0};
         wr(w);
         chk("setup", w & 12'hff7, setup);
      end
   endtask
   task automatic t_dac();
      wr(12'h301);
      wr(12'h410);
      chk("vref", 12'h3ff, {2'h0, vref});
      chk("setup", 12'h410, setup);
      wr(12'h101);
      wr(12'h0cd);
      chk("vref", 12'h0cd, {2'h0, vref});
      chk("setup", 12'h101, setup);
      wr(12'h103);
      rd(q);
      chk("dac read", 12'h0cd, q);
      wr(12'h104);
      wr(12'h0aa);
      chk("setup", 12'h104, setup);
      chk("vref", 12'h0cd, {2'h0, vref});
      wr(12'h005);
      chk("setup", 12'h000, setup);
      chk("vref", 12'h3ff, {2'h0, vref});
   endtask
   task automatic t_conv();
      conv(12'h9a5, 12'h05a, 1'b1);
      rd(q);
      chk("result a", 12'h1a5, q);
      rd(q);
      chk("result b", 12'h85a, q);
      rd(q);
      chk("third read", 12'h000, q);
      conv(12'hfff, 12'h000, 1'b1);
      rd(q);
      chk("full scale", 12'h7ff, q);
      rd(q);
      chk("negative scale", 12'h800, q);
   endtask
   task automatic t_sleep();
      wr(12'h080);
      conv(12'h000, 12'h000, 1'b0);
      chk("sleep", 12'h001, {11'h000, sleep});
      wr(12'h040);
      conv(12'h000, 12'h000, 1'b0);
      wr(12'h020);
      conv(12'h123, 12'h456, 1'b1);
      chk("sleep", 12'h001, {11'h000, sleep});
   endtask
   initial begin
      tick(2);
      rstn <= 1'b1;
      tick(1);
      t_defaults();
      t_setup();
      t_dac();
      t_conv();
      t_sleep();
      wr(12'h101);
      wr(12'h155);
      wr(12'h410);
      rstn <= 1'b0;
      tick(2);
      rstn <= 1'b1;
      tick(1);
      t_defaults();
      end_of_test();
   end
endmodule
